// ### rtl/fan_temp_pkg.sv
// Purpose: shared constants and types for the fan and temperature monitor
// Assumes: 50 MHz system clock, 8-bit register port
// Notes: register offsets and reset values live here only
package fan_temp_pkg;
	// Clock and reference time base
	localparam int CLK_HZ = 50_000_000;
	localparam int CLK_NS = 20;
	localparam int REF_HZ = 22_500;
	localparam int REF_CYCLES = CLK_HZ / REF_HZ;
	// Divisor 1 counts at twice the reference rate, so the base tick is half a period
	localparam int BASE_TICK_CYCLES = REF_CYCLES / 2;
	// Tach glitch filter: input must hold this long before it is believed
	localparam int FILT_NS = 2_000;
	localparam int FILT_CYCLES = (FILT_NS + CLK_NS - 1) / CLK_NS;
	// Monitoring loop period
	localparam int LOOP_MS = 1_000;
	localparam int LOOP_CYCLES = (CLK_HZ / 1_000) * LOOP_MS;
	localparam int NUM_FANS = 3;
	// Register offsets
	localparam logic [7:0] ADDR_TEMP = 8'h00;
	localparam logic [7:0] ADDR_OVERTEMP = 8'h01;
	localparam logic [7:0] ADDR_HYST = 8'h02;
	localparam logic [7:0] ADDR_FAN0 = 8'h03;
	localparam logic [7:0] ADDR_FANDIV = 8'h06;
	localparam logic [7:0] ADDR_STATUS = 8'h07;
	localparam logic [7:0] ADDR_MASK = 8'h08;
	localparam logic [7:0] ADDR_CTRL = 8'h09;
	// Reset values
	localparam logic [7:0] OVERTEMP_RST = 8'h50;
	localparam logic [7:0] HYST_RST = 8'h4B;
	localparam logic [7:0] TEMP_RST = 8'h00;
	localparam logic [7:0] FAN_RST = 8'hFF;
	localparam logic [3:0] FANDIV_RST = 4'h5;
	localparam logic [3:0] STATUS_RST = 4'h0;
	localparam logic [3:0] MASK_RST = 4'h0;
	localparam logic CTRL_START_RST = 1'b0;
	// Field positions and codes
	localparam int FANDIV0_LSB = 0;
	localparam int FANDIV1_LSB = 2;
	localparam int CTRL_START_BIT = 0;
	localparam int STAT_TEMP_BIT = 0;
	localparam int STAT_FAN0_BIT = 1;
	localparam logic [1:0] DIV_FIXED_CODE = 2'h1;
	localparam logic [7:0] FAN_FULL_SCALE = 8'hFF;
	localparam logic [7:0] COMPARATOR_HYST = 8'h7F;
	// Monitoring loop sequencer
	typedef enum logic [2:0] {
		LOOP_IDLE = 3'b000,
		LOOP_TEMP = 3'b001,
		LOOP_ANALOG = 3'b010,
		LOOP_FAN = 3'b011,
		LOOP_WAIT = 3'b100
	} loop_state_t;
	// Fan measurement phases
	typedef enum logic [1:0] {
		FAN_IDLE = 2'b00,
		FAN_ARM = 2'b01,
		FAN_COUNT = 2'b10
	} fan_state_t;
endpackage : fan_temp_pkg

// ### rtl/fan_tach_counter.sv
// Purpose: one tachometer channel: filter, edge detect, gated period count
// Assumes: tachIn is asynchronous and may have slow, noisy edges
// Notes: a missing or stalled tach yields full scale rather than hanging
`timescale 1ns/1ns
module fan_tach_counter (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Control
	input wire logic fanStart,
	input wire logic [1:0] divCode,
	// Tachometer pin
	input wire logic tachIn,
	// Result
	output logic fanDone,
	output logic [7:0] fanCount
);
	fan_temp_pkg::fan_state_t state_r;
	logic syncA_r;
	logic syncB_r;
	logic filt_r;
	logic filtDly_r;
	logic [15:0] stableCnt_r;
	logic [15:0] tickCnt_r;
	logic [15:0] tickLimit;
	logic tick;
	logic rise;

	// RULE6 two-flop sync
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			syncA_r <= 1'b0;
			syncB_r <= 1'b0;
		end else begin
			syncA_r <= tachIn;
			syncB_r <= syncA_r;
		end
	end

	// RULE6 stability filter, slow edges may chatter
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			stableCnt_r <= 16'h0000;
			filt_r <= 1'b0;
			filtDly_r <= 1'b0;
		end else begin
			filtDly_r <= filt_r;
			if (syncB_r == filt_r) begin
				stableCnt_r <= 16'h0000;
			end else if (stableCnt_r == 16'(fan_temp_pkg::FILT_CYCLES - 1)) begin
				stableCnt_r <= 16'h0000;
				filt_r <= syncB_r;
			end else begin
				stableCnt_r <= stableCnt_r + 16'h0001;
			end
		end
	end

	assign rise = filt_r & ~filtDly_r;
	// RULE5 tick period scales with divisor
	assign tickLimit = 16'(fan_temp_pkg::BASE_TICK_CYCLES) << divCode;
	assign tick = (tickCnt_r == tickLimit - 16'h0001);

	// RULE1 reference tick generator, restarted per measurement
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			tickCnt_r <= 16'h0000;
		end else if (fanStart || tick) begin
			tickCnt_r <= 16'h0000;
		end else begin
			tickCnt_r <= tickCnt_r + 16'h0001;
		end
	end

	// RULE1 gate ticks for one tach period
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_r <= fan_temp_pkg::FAN_IDLE;
			fanCount <= fan_temp_pkg::FAN_FULL_SCALE;
			fanDone <= 1'b0;
		end else begin
			fanDone <= 1'b0;
			unique case (state_r)
				fan_temp_pkg::FAN_IDLE: begin
					if (fanStart) begin
						// RULE18 restart from zero
						fanCount <= 8'h00;
						state_r <= fan_temp_pkg::FAN_ARM;
					end
				end
				fan_temp_pkg::FAN_ARM: begin
					if (rise) begin
						fanCount <= 8'h00;
						state_r <= fan_temp_pkg::FAN_COUNT;
					end else if (tick && fanCount == fan_temp_pkg::FAN_FULL_SCALE) begin
						// RULE2 no edge at all
						fanDone <= 1'b1;
						state_r <= fan_temp_pkg::FAN_IDLE;
					end else if (tick) begin
						fanCount <= fanCount + 8'h01;
					end
				end
				fan_temp_pkg::FAN_COUNT: begin
					if (rise) begin
						fanDone <= 1'b1;
						state_r <= fan_temp_pkg::FAN_IDLE;
					end else if (tick && fanCount == fan_temp_pkg::FAN_FULL_SCALE) begin
						// RULE2 saturate at 255
						fanDone <= 1'b1;
						state_r <= fan_temp_pkg::FAN_IDLE;
					end else if (tick) begin
						fanCount <= fanCount + 8'h01;
					end
				end
				default: begin
					state_r <= fan_temp_pkg::FAN_IDLE;
				end
			endcase
		end
	end
endmodule : fan_tach_counter

// ### rtl/fan_temp_monitor.sv
// Purpose: monitoring loop, fan speed readout, temperature limit interrupts
// Assumes: temperature converter and analog channels answer by done pulses
// Notes: registers are 8 bits on a simple strobe port, read data one cycle later
`timescale 1ns/1ns

//
// Contract
// RULE1 - Per fan, count 22.5 kHz reference during one tach period in 8 bits.
// RULE2 - Fan count saturates at 255; slow or stopped fan reads full scale.
// RULE3 - Fan divisors 1, 2, 4 or 8 supported; 2 after reset.
// RULE4 - Only fans one and two programmable; fan three fixed at divisor 2.
// RULE5 - Count equals 1.35 million over RPM times divisor, two pulses per rev.
// RULE6 - Fan inputs synchronised and filtered so slow edges give no false counts.
// RULE7 - Temperatures are 8-bit two's complement, one degree per count.
// RULE8 - Each conversion compares reading against overtemp and hysteresis setpoints.
// RULE9 - Interrupt mode: above overtemp sets latched interrupt until status read.
// RULE10 - After clearing, next interrupt only when reading drops below hysteresis.
// RULE11 - Hysteresis setpoint of 127 selects comparator mode.
// RULE12 - Comparator mode: status read clears; next cycle sets again if still over.
// RULE13 - Comparator mode: below overtemp stops reasserting within two cycles.
// RULE14 - Reading and both setpoints readable; only setpoints writable.
// RULE15 - Temperature interrupt cleared only by reading the status register.
// RULE16 - Loop: temperature, analog, three fans, in order, about once per second.
// RULE17 - Status read returns contents then clears until loop sets again.
// RULE18 - Fan count restarts each measurement; reading updates only on completion.
module fan_temp_monitor #(
	parameter int LOOP_CYCLES = fan_temp_pkg::LOOP_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Register port
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdData,
	// Temperature converter
	output logic tempReq,
	input wire logic tempDone,
	input wire logic [7:0] tempData,
	// Analog channel sweep
	output logic analogReq,
	input wire logic analogDone,
	// Fan tachometers
	input wire logic [2:0] tachIn,
	// Interrupt
	output logic irq
);
	// Loop sequencer; the period counter spans a full second at the system clock
	fan_temp_pkg::loop_state_t state_r;
	logic [31:0] loopCnt_r;
	logic [1:0] fanIdx_r;
	logic loopEnd;

	// Host-visible registers and the interrupt-mode direction flag
	logic [7:0] temp_r;
	logic [7:0] overtemp_setpoint_r;
	logic [7:0] hysteresis_setpoint_r;
	logic [3:0] fanDiv_r;
	logic [3:0] status_r;
	logic [3:0] mask_r;
	logic startEn_r;
	logic [7:0] fanVal_r [fan_temp_pkg::NUM_FANS];
	logic tripped_r;

	// Per-fan start, done and result wiring; entry i is fan i + 1
	logic [2:0] fanStart_r;
	logic [2:0] fanDone;
	logic [7:0] fanCount [fan_temp_pkg::NUM_FANS];
	logic [1:0] divCode [fan_temp_pkg::NUM_FANS];

	// Compare terms and status events, all settled within the cycle
	logic statusRead;
	logic tempOver;
	logic tempUnder;
	logic comparatorMode;
	logic tempEvent;
	logic [3:0] statusSet;

	// Loop period counter; frees the one-second spacing from conversion latency
	assign loopEnd = (loopCnt_r >= 32'(LOOP_CYCLES - 1));

	// Cleared while idle so the first loop after start runs a full period
	// RULE16 loop period timer
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			loopCnt_r <= 32'h0000_0000;
		end else if (state_r == fan_temp_pkg::LOOP_IDLE || (state_r == fan_temp_pkg::LOOP_WAIT && loopEnd)) begin
			loopCnt_r <= 32'h0000_0000;
		end else begin
			loopCnt_r <= loopCnt_r + 32'h0000_0001;
		end
	end

	// RULE16 round-robin sequencer
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_r <= fan_temp_pkg::LOOP_IDLE;
			fanIdx_r <= 2'h0;
			tempReq <= 1'b0;
			analogReq <= 1'b0;
			fanStart_r <= 3'h0;
		end else begin
			tempReq <= 1'b0;
			analogReq <= 1'b0;
			fanStart_r <= 3'h0;
			unique case (state_r)
				fan_temp_pkg::LOOP_IDLE: begin
					// Start is only looked at here and at the loop boundary
					if (startEn_r) begin
						tempReq <= 1'b1;
						state_r <= fan_temp_pkg::LOOP_TEMP;
					end
				end
				fan_temp_pkg::LOOP_TEMP: begin
					// Reading, compare and status all land on this same edge
					if (tempDone) begin
						analogReq <= 1'b1;
						state_r <= fan_temp_pkg::LOOP_ANALOG;
					end
				end
				fan_temp_pkg::LOOP_ANALOG: begin
					// Done pulses outside their wait state are simply ignored
					if (analogDone) begin
						fanIdx_r <= 2'h0;
						fanStart_r <= 3'h1;
						state_r <= fan_temp_pkg::LOOP_FAN;
					end
				end
				fan_temp_pkg::LOOP_FAN: begin
					// One fan at a time, in channel order
					if (fanDone[fanIdx_r]) begin
						// Fan three done closes the measuring part of the loop
						if (fanIdx_r == 2'(fan_temp_pkg::NUM_FANS - 1)) begin
							state_r <= fan_temp_pkg::LOOP_WAIT;
						end else begin
							fanIdx_r <= fanIdx_r + 2'h1;
							// Start pulse restarts the next channel's tick phase
							fanStart_r <= 3'h1 << (fanIdx_r + 2'h1);
						end
					end
				end
				fan_temp_pkg::LOOP_WAIT: begin
					// Stopping only takes effect at the loop boundary
					// A loop that overran its period starts again at once
					if (loopEnd) begin
						if (startEn_r) begin
							tempReq <= 1'b1;
							state_r <= fan_temp_pkg::LOOP_TEMP;
						end else begin
							state_r <= fan_temp_pkg::LOOP_IDLE;
						end
					end
				end
				default: begin
					// Unused codes fall back to idle
					state_r <= fan_temp_pkg::LOOP_IDLE;
				end
			endcase
		end
	end

	// RULE3 programmable fan divisors
	assign divCode[0] = fanDiv_r[fan_temp_pkg::FANDIV0_LSB +: 2];
	assign divCode[1] = fanDiv_r[fan_temp_pkg::FANDIV1_LSB +: 2];
	// RULE4 fan three divisor fixed
	assign divCode[2] = fan_temp_pkg::DIV_FIXED_CODE;

	// One counter per tach input
	generate
		for (genvar i = 0; i < fan_temp_pkg::NUM_FANS; i++) begin : g_fan
			// Each channel filters its own pin; no pin is shared
			fan_tach_counter u_fan (
				.clk(clk),
				.sys_rst(sys_rst),
				.fanStart(fanStart_r[i]),
				.divCode(divCode[i]),
				.tachIn(tachIn[i]),
				.fanDone(fanDone[i]),
				.fanCount(fanCount[i])
			);

			// A stalled measurement still ends in a done pulse, so this never freezes
			// RULE18 store only on completion
			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					fanVal_r[i] <= fan_temp_pkg::FAN_RST;
				end else if (fanDone[i]) begin
					fanVal_r[i] <= fanCount[i];
				end
			end
		end
	endgenerate

	// Compares use the live converter byte, valid only with its done pulse
	// RULE7 signed one-degree compares
	assign tempOver = $signed(tempData) > $signed(overtemp_setpoint_r);
	assign tempUnder = $signed(tempData) < $signed(hysteresis_setpoint_r);
	// RULE11 comparator mode select
	assign comparatorMode = (hysteresis_setpoint_r == fan_temp_pkg::COMPARATOR_HYST);

	// RULE8 compare on each conversion
	always_comb begin
		tempEvent = 1'b0;
		// Only the done pulse of a requested conversion counts
		if (state_r == fan_temp_pkg::LOOP_TEMP && tempDone) begin
			if (comparatorMode) begin
				// RULE12 RULE13 set only while over
				tempEvent = tempOver;
			end else if (!tripped_r) begin
				// RULE9 crossing above overtemp
				tempEvent = tempOver;
			end else begin
				// RULE10 re-arm below hysteresis after clear
				tempEvent = tempUnder && !status_r[fan_temp_pkg::STAT_TEMP_BIT];
			end
		end
	end

	// Interrupt-mode direction: waiting for high crossing or for low crossing
	// Comparator mode forgets the direction, so leaving it starts on a high crossing
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			tripped_r <= 1'b0;
		end else if (comparatorMode) begin
			tripped_r <= 1'b0;
		end else if (tempEvent) begin
			tripped_r <= ~tripped_r;
		end
	end

	// Held between conversions; host reads never disturb it
	// RULE7 latest temperature reading
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			temp_r <= fan_temp_pkg::TEMP_RST;
		end else if (state_r == fan_temp_pkg::LOOP_TEMP && tempDone) begin
			temp_r <= tempData;
		end
	end

	// Status events: temperature and fans that completed at full scale
	always_comb begin
		statusSet = 4'h0;
		statusSet[fan_temp_pkg::STAT_TEMP_BIT] = tempEvent;
		for (int i = 0; i < fan_temp_pkg::NUM_FANS; i++) begin
			statusSet[fan_temp_pkg::STAT_FAN0_BIT + i] = fanDone[i] && fanCount[i] == fan_temp_pkg::FAN_FULL_SCALE;
		end
	end

	// RULE17 clearing read strobe
	assign statusRead = regRd && regAddr == fan_temp_pkg::ADDR_STATUS;

	// RULE15 RULE17 read clears, set wins
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			status_r <= fan_temp_pkg::STATUS_RST;
		end else if (statusRead) begin
			// An event in the read cycle survives the clear
			status_r <= statusSet;
		end else begin
			status_r <= status_r | statusSet;
		end
	end

	// RULE14 only setpoints and controls writable
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			overtemp_setpoint_r <= fan_temp_pkg::OVERTEMP_RST;
			hysteresis_setpoint_r <= fan_temp_pkg::HYST_RST;
		end else if (regWr) begin
			// Reading and status have no write path at all
			if (regAddr == fan_temp_pkg::ADDR_OVERTEMP) begin
				overtemp_setpoint_r <= regWrData;
			end
			if (regAddr == fan_temp_pkg::ADDR_HYST) begin
				hysteresis_setpoint_r <= regWrData;
			end
		end
	end

	// RULE3 divisor codes, default divide by two
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			fanDiv_r <= fan_temp_pkg::FANDIV_RST;
		end else if (regWr && regAddr == fan_temp_pkg::ADDR_FANDIV) begin
			// Upper nibble is not stored and reads as zero
			fanDiv_r <= regWrData[3:0];
		end
	end

	// Mask and start control
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			mask_r <= fan_temp_pkg::MASK_RST;
			startEn_r <= fan_temp_pkg::CTRL_START_RST;
		end else if (regWr) begin
			if (regAddr == fan_temp_pkg::ADDR_MASK) begin
				mask_r <= regWrData[3:0];
			end
			if (regAddr == fan_temp_pkg::ADDR_CTRL) begin
				// Clearing start lets the current loop finish first
				startEn_r <= regWrData[fan_temp_pkg::CTRL_START_BIT];
			end
		end
	end

	// RULE14 read mux, unmapped reads as zero
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			regRdData <= 8'h00;
		end else if (regRd) begin
			unique case (regAddr)
				fan_temp_pkg::ADDR_TEMP: regRdData <= temp_r;
				fan_temp_pkg::ADDR_OVERTEMP: regRdData <= overtemp_setpoint_r;
				fan_temp_pkg::ADDR_HYST: regRdData <= hysteresis_setpoint_r;
				// Fan readings hold the last completed measurement
				fan_temp_pkg::ADDR_FAN0: regRdData <= fanVal_r[0];
				fan_temp_pkg::ADDR_FAN0 + 8'h01: regRdData <= fanVal_r[1];
				fan_temp_pkg::ADDR_FAN0 + 8'h02: regRdData <= fanVal_r[2];
				fan_temp_pkg::ADDR_FANDIV: regRdData <= {4'h0, fanDiv_r};
				// Status is returned as it stood before this read clears it
				fan_temp_pkg::ADDR_STATUS: regRdData <= {4'h0, status_r};
				fan_temp_pkg::ADDR_MASK: regRdData <= {4'h0, mask_r};
				fan_temp_pkg::ADDR_CTRL: regRdData <= {7'h00, startEn_r};
				default: regRdData <= 8'h00;
			endcase
		end else begin
			// Bus idles at zero so a stale byte never passes for an answer
			regRdData <= 8'h00;
		end
	end

	// Masked status bits still latch and can be polled
	// Level interrupt; registered so it drops two cycles after a clearing read strobe
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status_r & mask_r);
		end
	end
endmodule : fan_temp_monitor

// ### dv/fan_temp_monitor_asserts.sv
// Purpose: port checks for the fan and temperature monitor
// Assumes: one clock, async active-high reset
// Notes: irq lags its status bit by one cycle
`timescale 1ns/1ns
module fan_temp_monitor_asserts (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Register port
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [7:0] regRdData,
	// Loop handshakes
	input wire logic tempReq,
	input wire logic tempDone,
	input wire logic analogReq,
	// Interrupt
	input wire logic irq
);
	logic tempWait_r;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// A stray done pulse outside the wait must not count as a cause
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			tempWait_r <= 1'b0;
		end else if (tempReq) begin
			tempWait_r <= 1'b1;
		end else if (tempDone) begin
			tempWait_r <= 1'b0;
		end
	end
	// Setpoint written, then read back at once
	sequence s_hyst_wr_rd;
		(regWr && regAddr == fan_temp_pkg::ADDR_HYST) ##1 (regRd && regAddr == fan_temp_pkg::ADDR_HYST);
	endsequence
	a_read_idle: assert property (!$past(regRd) |-> regRdData == 8'h00)
		else $error("read data not zero outside answer");
	a_unmapped_zero: assert property (regRd && regAddr > fan_temp_pkg::ADDR_CTRL |=> regRdData == 8'h00)
		else $error("unmapped read not zero");
	a_setpoint_back: assert property (s_hyst_wr_rd |=> regRdData == $past(regWrData, 2))
		else $error("setpoint read back wrong");
	a_temp_pulse: assert property (tempReq |=> !tempReq)
		else $error("temp request too long");
	a_analog_pulse: assert property (analogReq |=> !analogReq)
		else $error("analog request too long");
	a_analog_after: assert property (tempWait_r && tempDone |=> analogReq)
		else $error("analog sweep not started");
	a_analog_cause: assert property (analogReq |-> $past(tempDone))
		else $error("analog sweep without conversion");
	a_irq_fall_read: assert property ($fell(irq) |-> ($past(regRd, 2) && $past(regAddr, 2) ==
		fan_temp_pkg::ADDR_STATUS) || $past(regWr, 2))
		else $error("irq cleared without status read");
endmodule : fan_temp_monitor_asserts
bind fan_temp_monitor fan_temp_monitor_asserts chk_u (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
	.regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .tempReq(tempReq),
	.tempDone(tempDone), .analogReq(analogReq), .irq(irq));

// ### dv/far_side_model.sv
// Purpose: fan tachometers, temperature converter and analog sweep
// Assumes: converter answers a fixed delay after each request
// Notes: rising tach edges bounce briefly, as slow edges do at a threshold
`timescale 1ns/1ns
module far_side_model (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Test controls
	input wire logic [15:0] tachPeriod,
	input wire logic [7:0] tempVal,
	// Requests
	input wire logic tempReq,
	input wire logic analogReq,
	// Answers
	output logic tempDone,
	output logic [7:0] tempData,
	output logic analogDone,
	output logic [2:0] tachOut
);
	logic [15:0] tachCnt_r;
	logic [7:0] tempDly_r;
	logic [7:0] anaDly_r;
	// Fans spin freely, two pulses a revolution
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			tachCnt_r <= 16'h0000;
			tempDly_r <= 8'h00;
			anaDly_r <= 8'h00;
		end else begin
			tachCnt_r <= (tachCnt_r >= tachPeriod - 16'h0001) ? 16'h0000 : tachCnt_r + 16'h0001;
			tempDly_r <= tempReq ? 8'h3C : (tempDly_r != 8'h00 ? tempDly_r - 8'h01 : 8'h00);
			anaDly_r <= analogReq ? 8'h1E : (anaDly_r != 8'h00 ? anaDly_r - 8'h01 : 8'h00);
		end
	end
	assign tachOut = {3{tachCnt_r < 16'h0010 ? tachCnt_r[1] : tachCnt_r < (tachPeriod >> 1)}};
	assign tempDone = tempDly_r == 8'h01;
	assign analogDone = anaDly_r == 8'h01;
	// Stale data is inverted so it never passes for a fresh reading
	assign tempData = tempDone ? tempVal : ~tempVal;
endmodule : far_side_model

// ### dv/fan_temp_monitor_tb.sv
// Purpose: self-checking bench for the fan and temperature monitor
// Assumes: short loop period; tach periods only one to four ticks long
// Notes: fan counts may read one high, by tick phase
`timescale 1ns/1ns
module fan_temp_monitor_tb;
	typedef struct packed {
		logic [7:0] val;
		logic tol;
	} note_t;
	logic clk, sys_rst, regWr, regRd, rdSeen, tempReq, tempDone, analogReq, analogDone, irq;
	logic [7:0] regAddr, regWrData, regRdData, tempData, tempVal, setOver;
	logic [7:0] rstVal [11];
	logic [15:0] tachPeriod;
	logic [2:0] tachIn;
	note_t notes[$];
	int err_total = 0;
	int tests_run = 0;
	int seed = 89;
	fan_temp_monitor #(.LOOP_CYCLES(2000)) dut_u (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .tempReq(tempReq),
		.tempDone(tempDone), .tempData(tempData), .analogReq(analogReq), .analogDone(analogDone),
		.tachIn(tachIn), .irq(irq));
	far_side_model far_u (.clk(clk), .sys_rst(sys_rst), .tachPeriod(tachPeriod), .tempVal(tempVal),
		.tempReq(tempReq), .analogReq(analogReq), .tempDone(tempDone), .tempData(tempData),
		.analogDone(analogDone), .tachOut(tachIn));
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : print_verdict
	task automatic cmp_byte(input logic [7:0] got, input note_t n);
		tests_run++;
		if (!(got === n.val || (n.tol && got === n.val + 8'h01))) begin
			err_total++;
			$display("CHECK FAILED at %0t read %h expected %h", $time, got, n.val);
		end
	endtask : cmp_byte
	task automatic check_irq(input logic e);
		repeat (2) @(posedge clk);
		@(negedge clk);
		tests_run++;
		if (irq !== e) begin
			err_total++;
			$display("CHECK FAILED at %0t irq %h expected %h", $time, irq, e);
		end
	endtask : check_irq
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		regRd <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic t);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		regWr <= 1'b0;
		notes.push_back('{e, t});
	endtask : rd
	task automatic idle;
		@(posedge clk);
		regWr <= 1'b0;
		regRd <= 1'b0;
		regWrData <= 8'($random(seed));
	endtask : idle
	// Bounded wait for a loop request, analog sweep or temperature
	task automatic wait_req(input logic useAnalog);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (!(useAnalog ? analogReq : tempReq) && n < 40000);
		if (n >= 40000) begin
			err_total++;
			print_verdict();
		end
	endtask : wait_req
	task automatic conv(input logic e);
		wait_req(1'b1);
		check_irq(e);
	endtask : conv
	function automatic logic [7:0] fanExp(input int sh);
		return 8'(int'(tachPeriod) / (fan_temp_pkg::BASE_TICK_CYCLES << sh));
	endfunction : fanExp
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Read data stands one cycle after the strobe; pair it with the oldest note
	always @(posedge clk) begin
		rdSeen <= regRd;
		if (rdSeen && notes.size() > 0) begin
			cmp_byte(regRdData, notes.pop_front());
		end
	end
	initial begin
		sys_rst = 1'b1;
		regAddr = 8'h00;
		regWrData = 8'h00;
		regWr = 1'b0;
		regRd = 1'b0;
		tempVal = 8'h00;
		tachPeriod = 16'h1350;
		rstVal = '{8'h00, fan_temp_pkg::OVERTEMP_RST, fan_temp_pkg::HYST_RST, 8'hFF, 8'hFF, 8'hFF, 8'h05,
			8'h00, 8'h00, 8'h00, 8'h00};
		setOver = 8'h10 + (8'($random(seed)) & 8'h1F);
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		for (int i = 0; i < 11; i++) rd(8'(i), rstVal[i], 1'b0);
		wr(fan_temp_pkg::ADDR_TEMP, 8'h33);
		wr(fan_temp_pkg::ADDR_FAN0, 8'h12);
		wr(fan_temp_pkg::ADDR_OVERTEMP, setOver);
		rd(fan_temp_pkg::ADDR_OVERTEMP, setOver, 1'b0);
		wr(fan_temp_pkg::ADDR_HYST, setOver - 8'h0A);
		rd(fan_temp_pkg::ADDR_HYST, setOver - 8'h0A, 1'b0);
		rd(fan_temp_pkg::ADDR_TEMP, 8'h00, 1'b0);
		rd(fan_temp_pkg::ADDR_FAN0, 8'hFF, 1'b0);
		wr(fan_temp_pkg::ADDR_FANDIV, 8'h08);
		rd(fan_temp_pkg::ADDR_FANDIV, 8'h08, 1'b0);
		wr(fan_temp_pkg::ADDR_MASK, 8'h01);
		tempVal <= setOver + 8'h01;
		wr(fan_temp_pkg::ADDR_CTRL, 8'h01);
		idle();
		$display("register access done");
		conv(1'b1);
		wait_req(1'b0);
		rd(fan_temp_pkg::ADDR_FAN0, fanExp(0), 1'b1);
		rd(fan_temp_pkg::ADDR_FAN0 + 8'h01, fanExp(2), 1'b1);
		rd(fan_temp_pkg::ADDR_FAN0 + 8'h02, fanExp(1), 1'b1);
		idle();
		tachPeriod <= 16'h0457;
		$display("fan counts done");
		check_irq(1'b1);
		rd(fan_temp_pkg::ADDR_STATUS, 8'h01, 1'b0);
		rd(fan_temp_pkg::ADDR_STATUS, 8'h00, 1'b0);
		idle();
		check_irq(1'b0);
		conv(1'b0);
		tempVal <= 8'hE7;
		conv(1'b1);
		rd(fan_temp_pkg::ADDR_TEMP, 8'hE7, 1'b0);
		rd(fan_temp_pkg::ADDR_STATUS, 8'h01, 1'b0);
		wr(fan_temp_pkg::ADDR_HYST, 8'h7F);
		idle();
		tempVal <= 8'h7D;
		$display("interrupt mode done");
		conv(1'b1);
		wr(fan_temp_pkg::ADDR_MASK, 8'h00);
		idle();
		check_irq(1'b0);
		wr(fan_temp_pkg::ADDR_MASK, 8'h01);
		rd(fan_temp_pkg::ADDR_STATUS, 8'h01, 1'b0);
		idle();
		check_irq(1'b0);
		conv(1'b1);
		rd(fan_temp_pkg::ADDR_STATUS, 8'h01, 1'b0);
		idle();
		tempVal <= setOver;
		conv(1'b0);
		rd(fan_temp_pkg::ADDR_TEMP, setOver, 1'b0);
		wr(fan_temp_pkg::ADDR_CTRL, 8'h00);
		idle();
		repeat (3) @(posedge clk);
		$display("comparator mode done");
		print_verdict();
	end
endmodule : fan_temp_monitor_tb
